// file: hw/adc_conversion_sequencer.sv
// Overview of operation
// - setting the trigger bit or load-defaults bit starts a conversion
// - conversion is N elementary conversions back to back, then one quantization step
// - each elementary conversion lasts OSR plus one sample periods
// - result is the mean of the elementary results
// - offset polarity alternates between successive elementary conversions
// - a few extra clock cycles open and close each conversion
// - reference chop: held high, held low, toggle each, toggle every second
// - rate code 00..11 selects 62.5, 125, 250, 500 kHz from 4 MHz
// - OSR is two to the power of three plus the ratio code
// - elementary count is two to the count code: 1, 2, 4, 8
// - result register is 16 bits, resolution truncated there
// - gain code is 7-bit unsigned, gain equals code over twelve
// - offset code is 7-bit sign-magnitude in twelfths
// - busy flag reads one while a conversion runs
// - load-defaults restores settings and restarts, abandoning any conversion
// - continuous mode restarts at once, writes result, pulses completion
// - conversion spans N times (OSR plus one) plus one sample periods
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer
   import adc_seq_pkg::*;
(
   input  wire logic             pclk,          // 125 MHz clock
   input  wire logic             presetn,       // async reset, low
   input  wire logic             psel,          // apb select
   input  wire logic             penable,       // apb access phase
   input  wire logic             pwrite,        // apb direction
   input  wire logic [11:0]      paddr,         // apb byte address
   input  wire logic [31:0]      pwdata,        // apb write data
   output logic      [31:0]      prdata,        // apb read data
   output logic                  pready,        // apb ready
   output logic                  pslverr,       // apb error
   input  wire logic             mod_bit,       // modulator comparator bit
   output conv_cfg_t             cfg,           // settings to analog chain
   output logic                  mod_enable,    // modulator running
   output logic                  offset_pol,    // amplifier offset polarity
   output logic                  ref_chop,      // bandgap chop control
   output logic      [RES_W-1:0] result,        // last conversion result
   output logic                  conv_done      // completion trigger pulse
);
   conv_cfg_t               cfg_ff;
   conv_cfg_t               nxt_cfg;
   seq_state_t              st_ff;
   seq_state_t              nxt_st;
   logic [31:0]             prdata_ff;
   logic [31:0]             rd_mux;
   logic [2:0]              cyc_ff;
   logic [10:0]             per_ff;
   logic [2:0]              el_ff;
   logic signed [S1_W-1:0]  s1_ff;
   logic signed [S2_W-1:0]  s2_ff;
   logic signed [SUM_W-1:0] sum_ff;
   logic                    pol_ff;
   logic                    chop_ff;
   logic [RES_W-1:0]        result_ff;
   logic                    done_ff;
   logic                    mod_meta_ff;
   logic                    mod_sync_ff;
   logic                    fs_tick;

   // modulator bit is asynchronous to pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_meta_ff <= 1'b0;
         mod_sync_ff <= 1'b0;
      end else begin
         mod_meta_ff <= mod_bit;
         mod_sync_ff <= mod_meta_ff;
      end
   end

   sample_rate_gen u_rate (
      .pclk      (pclk),
      .presetn   (presetn),
      .rate_code (cfg_ff.rate),
      .fs_tick   (fs_tick)
   );

   // apb decode; zero wait states, read data captured in the setup phase
   logic setup_ph;
   logic access_ph;
   logic hit_a;
   logic hit_b;
   logic hit_c;
   logic hit_d;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_res;
   logic mapped;
   logic wr_en;
   logic busy;
   logic start_wr;
   logic def_wr;
   logic start_go;
   assign setup_ph  = psel && !penable;
   assign access_ph = psel && penable;
   assign hit_a     = (paddr == ADDR_CFG_A);
   assign hit_b     = (paddr == ADDR_CFG_B);
   assign hit_c     = (paddr == ADDR_CFG_C);
   assign hit_d     = (paddr == ADDR_CFG_D);
   assign hit_ctrl  = (paddr == ADDR_CTRL);
   assign hit_stat  = (paddr == ADDR_STATUS);
   assign hit_res   = (paddr == ADDR_RESULT);
   assign mapped    = hit_a | hit_b | hit_c | hit_d | hit_ctrl | hit_stat | hit_res;
   assign wr_en     = access_ph && pwrite && mapped;
   assign pready    = 1'b1;
   assign pslverr   = access_ph && !mapped;
   assign prdata    = prdata_ff;
   assign busy      = (st_ff != ST_IDLE);
   assign start_wr  = wr_en && hit_a && pwdata[START_BIT];
   assign def_wr    = wr_en && hit_ctrl && pwdata[DEF_BIT];
   // trigger is a strobe, never stored, and ignored while running
   assign start_go  = start_wr && !busy;

   // read mux; trigger and load-defaults read back as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_a) begin
         rd_mux[OSR_LSB +: 3]  = cfg_ff.osr;
         rd_mux[CNT_LSB +: 2]  = cfg_ff.cnt;
         rd_mux[CONT_BIT]      = cfg_ff.cont;
         rd_mux[CHOP_LSB +: 2] = cfg_ff.chop;
      end else if (hit_b) begin
         rd_mux[RATE_LSB +: 2] = cfg_ff.rate;
      end else if (hit_c) begin
         rd_mux[6:0] = cfg_ff.gain;
      end else if (hit_d) begin
         rd_mux[6:0] = cfg_ff.offs;
      end else if (hit_stat) begin
         rd_mux[BUSY_BIT] = busy;
      end else if (hit_res) begin
         rd_mux[RES_W-1:0] = result_ff;
      end
   end

   // configuration writes; load-defaults overrides any field write
   always_comb begin
      nxt_cfg = cfg_ff;
      if (def_wr) begin
         nxt_cfg = '{rate: RATE_DEF, osr: OSR_DEF, cnt: CNT_DEF, cont: 1'b0,
                     chop: CHOP_DEF, gain: GAIN_DEF, offs: OFFS_DEF};
      end else if (wr_en) begin
         if (hit_a) begin
            nxt_cfg.osr  = pwdata[OSR_LSB +: 3];
            nxt_cfg.cnt  = pwdata[CNT_LSB +: 2];
            nxt_cfg.cont = pwdata[CONT_BIT];
            nxt_cfg.chop = pwdata[CHOP_LSB +: 2];
         end
         if (hit_b) nxt_cfg.rate = pwdata[RATE_LSB +: 2];
         if (hit_c) nxt_cfg.gain = pwdata[6:0]; // unsigned twelfths
         if (hit_d) nxt_cfg.offs = pwdata[6:0]; // sign-magnitude, passed as is
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff    <= '{rate: RATE_DEF, osr: OSR_DEF, cnt: CNT_DEF, cont: 1'b0,
                        chop: CHOP_DEF, gain: GAIN_DEF, offs: OFFS_DEF};
         prdata_ff <= 32'h0000_0000;
      end else begin
         cfg_ff    <= nxt_cfg;
         prdata_ff <= setup_ph ? rd_mux : prdata_ff;
      end
   end

   // sequence arithmetic
   logic [10:0]            osr_val;
   logic [2:0]             el_last_idx;
   logic                   per_end;
   logic                   el_end;
   logic                   last_el;
   logic signed [S1_W-1:0] s1_add;
   logic signed [S2_W-1:0] s2_add;
   logic signed [SUM_W-1:0] el_term;
   logic signed [SUM_W-1:0] sum_add;
   logic signed [SUM_W+RES_W-1:0] wide;
   logic signed [SUM_W+RES_W-1:0] scaled;
   logic [5:0]             shamt;
   logic [RES_W-1:0]       sat_res;
   assign osr_val     = 11'(11'h008 << cfg_ff.osr);
   assign el_last_idx = 3'((4'h1 << cfg_ff.cnt) - 4'h1);
   // osr+1 ticks counted 0..osr close one elementary conversion
   assign per_end     = (st_ff == ST_ELCONV) && fs_tick && (per_ff == osr_val);
   assign el_end      = per_end;
   assign last_el     = (el_ff == el_last_idx);
   // second-order incremental integration of the modulator bit
   assign s1_add      = mod_sync_ff ? S1_W'(s1_ff + 12'h001) : S1_W'(s1_ff - 12'h001);
   assign s2_add      = S2_W'(s2_ff + S2_W'(s1_add));
   // undo the chopped polarity so the amplifier offset cancels in the sum
   assign el_term     = pol_ff ? -SUM_W'(s2_add) : SUM_W'(s2_add);
   assign sum_add     = SUM_W'(sum_ff + el_term);
   // mean of N results normalised to 16 bits: sum * 2^16 / (N * OSR^2)
   assign shamt       = 6'(6'(2 * (cfg_ff.osr + 3'h3)) + 6'(cfg_ff.cnt));
   assign wide        = (SUM_W+RES_W)'(sum_ff) <<< RES_W;
   assign scaled      = wide >>> shamt;
   // truncate to the 16-bit register by saturating to full scale
   assign sat_res     = (scaled > 41'sh0_0000_7FFF) ? 16'h7FFF :
                        (scaled < -41'sh0_0000_8000) ? 16'h8000 : scaled[RES_W-1:0];

   // state machine
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE:   if (start_go) nxt_st = ST_SETUP;
         ST_SETUP:  if (cyc_ff == SETUP_CYCLES - 3'h1) nxt_st = ST_ALIGN;
         ST_ALIGN:  if (fs_tick) nxt_st = ST_ELCONV;
         ST_ELCONV: if (el_end && last_el) nxt_st = ST_QUANT;
         ST_QUANT:  if (fs_tick) nxt_st = ST_CLOSE;
         ST_CLOSE: begin
            if (cyc_ff == CLOSE_CYCLES - 3'h1) begin
               nxt_st = cfg_ff.cont ? ST_SETUP : ST_IDLE;
            end
         end
         default:   nxt_st = ST_IDLE;
      endcase
      if (def_wr) nxt_st = ST_SETUP;
   end

   logic close_end;
   logic enter_setup;
   assign close_end   = (st_ff == ST_CLOSE) && (cyc_ff == CLOSE_CYCLES - 3'h1);
   assign enter_setup = (nxt_st == ST_SETUP) && (st_ff != ST_SETUP || def_wr);

   // cycle counter for setup and close, period and elementary counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff  <= ST_IDLE;
         cyc_ff <= 3'h0;
         per_ff <= 11'h000;
         el_ff  <= 3'h0;
      end else begin
         st_ff  <= nxt_st;
         cyc_ff <= (nxt_st != st_ff || def_wr) ? 3'h0 : 3'(cyc_ff + 3'h1);
         per_ff <= (st_ff != ST_ELCONV || per_end) ? 11'h000 :
                   fs_tick ? 11'(per_ff + 11'h001) : per_ff;
         el_ff  <= enter_setup ? 3'h0 : el_end ? 3'(el_ff + 3'h1) : el_ff;
      end
   end

   // integrators clear at each elementary boundary; sum clears per conversion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff  <= '0;
         s2_ff  <= '0;
         sum_ff <= '0;
      end else begin
         s1_ff  <= (st_ff != ST_ELCONV || el_end) ? '0 : fs_tick ? s1_add : s1_ff;
         s2_ff  <= (st_ff != ST_ELCONV || el_end) ? '0 : fs_tick ? s2_add : s2_ff;
         sum_ff <= enter_setup ? '0 : el_end ? sum_add : sum_ff;
      end
   end

   // offset polarity and bandgap chop
   logic nxt_chop;
   always_comb begin
      nxt_chop = chop_ff;
      if (enter_setup) begin
         nxt_chop = (cfg_ff.chop != CHOP_LOW);
      end else if (!busy) begin
         nxt_chop = (cfg_ff.chop != CHOP_LOW);
      end else if (el_end && cfg_ff.chop == CHOP_EACH) begin
         nxt_chop = !chop_ff;
      end else if (el_end && cfg_ff.chop == CHOP_HALF && el_ff[0]) begin
         nxt_chop = !chop_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol_ff    <= 1'b0;
         chop_ff   <= 1'b1;
         result_ff <= 16'h0000;
         done_ff   <= 1'b0;
      end else begin
         pol_ff    <= enter_setup ? 1'b0 : el_end ? !pol_ff : pol_ff;
         chop_ff   <= nxt_chop;
         result_ff <= (close_end && !def_wr) ? sat_res : result_ff;
         done_ff   <= close_end && !def_wr;
      end
   end

   assign cfg        = cfg_ff;
   assign mod_enable = busy;
   assign offset_pol = pol_ff;
   assign ref_chop   = chop_ff;
   assign result     = result_ff;
   assign conv_done  = done_ff;

   // the host is expected to pick two or more elementary conversions
   a_start_begins: assert property (@(posedge pclk) disable iff (!presetn)
      (start_wr && !busy) |=> (st_ff == ST_SETUP))
      else $error("trigger did not start a conversion");
   a_start_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (start_wr && st_ff == ST_ELCONV && !def_wr) |=> (st_ff != ST_SETUP))
      else $error("trigger restarted a running conversion");
   a_def_restart: assert property (@(posedge pclk) disable iff (!presetn)
      def_wr |=> (st_ff == ST_SETUP && cyc_ff == 3'h0 && cfg_ff.osr == OSR_DEF
                  && cfg_ff.cnt == CNT_DEF && cfg_ff.rate == RATE_DEF))
      else $error("load-defaults did not reload and restart");
   a_elconv_length: assert property (@(posedge pclk) disable iff (!presetn)
      (st_ff == ST_ELCONV && fs_tick) |-> (per_ff <= osr_val))
      else $error("elementary conversion overran");
   a_pol_alternate: assert property (@(posedge pclk) disable iff (!presetn)
      (el_end && !last_el && !def_wr) |=> (offset_pol == !$past(offset_pol)))
      else $error("offset polarity did not alternate");
   a_el_count: assert property (@(posedge pclk) disable iff (!presetn)
      (el_end && last_el && !def_wr) |=> (st_ff == ST_QUANT && el_ff == 3'(el_last_idx + 3'h1)))
      else $error("wrong number of elementary conversions");
   a_quant_one: assert property (@(posedge pclk) disable iff (!presetn)
      (st_ff == ST_QUANT && fs_tick && !def_wr) |=> (st_ff == ST_CLOSE) ##1 (st_ff == ST_CLOSE))
      else $error("quantization step not one period");
   a_busy_read: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_ph && hit_stat) |=> (prdata[BUSY_BIT] == $past(busy)))
      else $error("busy flag misread");
   a_chop_held: assert property (@(posedge pclk) disable iff (!presetn)
      (st_ff == ST_ELCONV && cfg_ff.chop == CHOP_HIGH) |-> ref_chop)
      else $error("chop not held high");
   a_cont_restart: assert property (@(posedge pclk) disable iff (!presetn)
      (conv_done && cfg_ff.cont) |-> (st_ff == ST_SETUP && result == $past(sat_res)))
      else $error("continuous mode did not restart");

   c_single_conv: cover property (@(posedge pclk) disable iff (!presetn)
      conv_done && !cfg_ff.cont);
   c_cont_conv: cover property (@(posedge pclk) disable iff (!presetn)
      conv_done && cfg_ff.cont);
   c_def_abort: cover property (@(posedge pclk) disable iff (!presetn)
      def_wr && st_ff == ST_ELCONV);
   c_chop_half: cover property (@(posedge pclk) disable iff (!presetn)
      el_end && cfg_ff.chop == CHOP_HALF);
endmodule
`default_nettype wire

// file: hw/adc_seq_pkg.sv
package adc_seq_pkg;

   // clock rates, in kHz as printed
   localparam int PCLK_FREQ_KHZ = 125000;
   localparam int OSC_FREQ_KHZ  = 4000;
   // phase accumulator turning pclk into an average 4 MHz tick
   localparam logic [7:0] OSC_STEP  = 8'(OSC_FREQ_KHZ / 1000);
   localparam logic [7:0] PHASE_MOD = 8'(PCLK_FREQ_KHZ / 1000);
   // slowest divider (62.5 kHz) is 8 times the fastest (500 kHz)
   localparam logic [5:0] FS_DIV_MIN = 6'h08;

   // register byte addresses
   localparam logic [11:0] ADDR_CFG_A  = 12'h000;
   localparam logic [11:0] ADDR_CFG_B  = 12'h004;
   localparam logic [11:0] ADDR_CFG_C  = 12'h008;
   localparam logic [11:0] ADDR_CFG_D  = 12'h00C;
   localparam logic [11:0] ADDR_CTRL   = 12'h010;
   localparam logic [11:0] ADDR_STATUS = 12'h014;
   localparam logic [11:0] ADDR_RESULT = 12'h018;

   // field positions
   localparam int START_BIT = 0;
   localparam int OSR_LSB   = 2;
   localparam int CNT_LSB   = 5;
   localparam int CONT_BIT  = 7;
   localparam int CHOP_LSB  = 8;
   localparam int RATE_LSB  = 6;
   localparam int DEF_BIT   = 0;
   localparam int BUSY_BIT  = 0;

   // reset and load-defaults values
   localparam logic [1:0] RATE_DEF = 2'h3;
   localparam logic [2:0] OSR_DEF  = 3'h2;
   localparam logic [1:0] CNT_DEF  = 2'h1;
   localparam logic [1:0] CHOP_DEF = 2'h0;
   localparam logic [6:0] GAIN_DEF = 7'h00;
   localparam logic [6:0] OFFS_DEF = 7'h00;

   // reference chopping modes
   localparam logic [1:0] CHOP_HIGH = 2'h0;
   localparam logic [1:0] CHOP_LOW  = 2'h1;
   localparam logic [1:0] CHOP_EACH = 2'h2;
   localparam logic [1:0] CHOP_HALF = 2'h3;

   // pclk cycles spent opening and closing a conversion
   localparam logic [2:0] SETUP_CYCLES = 3'h4;
   localparam logic [2:0] CLOSE_CYCLES = 3'h2;

   localparam int S1_W  = 12;
   localparam int S2_W  = 22;
   localparam int SUM_W = 25;
   localparam int RES_W = 16;

   typedef struct packed {
      logic [1:0] rate;
      logic [2:0] osr;
      logic [1:0] cnt;
      logic       cont;
      logic [1:0] chop;
      logic [6:0] gain;
      logic [6:0] offs;
   } conv_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_ALIGN,
      ST_ELCONV,
      ST_QUANT,
      ST_CLOSE
   } seq_state_t;

endpackage

// file: hw/sample_rate_gen.sv
`timescale 1ns/1ns
`default_nettype none
module sample_rate_gen
   import adc_seq_pkg::*;
(
   input  wire logic       pclk,      // bus clock
   input  wire logic       presetn,   // async reset, low
   input  wire logic [1:0] rate_code, // sample rate select
   output logic            fs_tick    // one pclk per sample period
);
   logic [7:0] acc_ff;
   logic [5:0] div_ff;
   logic [5:0] div_last;
   logic [7:0] acc_sum;
   logic       osc_tick;

   // fractional accumulator: 125 is not a multiple of 4, so ticks jitter by one pclk
   assign acc_sum  = acc_ff + OSC_STEP;
   assign osc_tick = (acc_sum >= PHASE_MOD);
   // divide by 64, 32, 16 or 8
   assign div_last = 6'((FS_DIV_MIN << (2'h3 - rate_code)) - 6'h01);
   // >= keeps a raised rate code from overrunning the counter
   assign fs_tick  = osc_tick && (div_ff >= div_last);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff <= 8'h00;
         div_ff <= 6'h00;
      end else begin
         acc_ff <= osc_tick ? 8'(acc_sum - PHASE_MOD) : acc_sum;
         if (osc_tick) begin
            div_ff <= fs_tick ? 6'h00 : 6'(div_ff + 6'h01);
         end
      end
   end

   a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
      fs_tick |=> !fs_tick [*8])
      else $error("sample ticks too close");
endmodule
`default_nettype wire

// file: bench/host_model.sv
`timescale 1ns/1ns
`default_nettype none
// apb master standing in for the host controller
module host_model
   import adc_seq_pkg::*;
(
   input  wire logic        pclk,    // bus clock
   output logic             psel,    // select
   output logic             penable, // access phase
   output logic             pwrite,  // direction
   output logic [11:0]      paddr,   // byte address
   output logic [31:0]      pwdata,  // write data
   input  wire logic [31:0] prdata,  // read data
   input  wire logic        pready,  // ready
   input  wire logic        pslverr  // error
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end

   // request held until pready is seen at a rising edge, then released
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // count code fixed at two elementary runs so offsets cancel
   task automatic start(input logic [2:0] osr, input logic cont);
      logic [31:0] q;
      logic        e;
      xfer(1'b1, ADDR_CFG_A, {24'h0, cont, 2'h1, osr, 2'h1}, q, e);
   endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fails++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
   import adc_seq_pkg::*;
   typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic err;} row_t;
   logic pclk, presetn, mod_bit, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic e, mod_enable, offset_pol, pol_q, ref_chop, conv_done, fs_tick;
   logic chop_q, follow_pol;
   logic [RES_W-1:0] result;
   conv_cfg_t cfg;
   int fails, n_tests, n, tog, ctog;
   // 500 kHz, 2 x (8+1)+1 ticks of about 250 pclk, default 2 x (32+1)+1
   localparam int LO1 = 19 * 249 + 4;
   localparam int HI1 = 20 * 251 + 10;
   localparam int LO2 = 67 * 249 + 4;
   localparam int HI2 = 68 * 251 + 10;
   row_t rows [9] = '{
      '{ADDR_CFG_B, 32'h00000040, 32'h00000040, 1'b0}, '{ADDR_CFG_B, 32'hFFFFFFFF, 32'h000000C0, 1'b0},
      '{ADDR_CFG_C, 32'hFFFFFFFF, 32'h0000007F, 1'b0}, '{ADDR_CFG_D, 32'h00000040, 32'h00000040, 1'b0},
      '{ADDR_CFG_D, 32'h0000003F, 32'h0000003F, 1'b0}, '{ADDR_CFG_A, 32'h000003FC, 32'h000003FC, 1'b0},
      '{ADDR_CFG_A, 32'h00000000, 32'h00000000, 1'b0}, '{ADDR_STATUS, 32'h00000001, 32'h0, 1'b0},
      '{12'h01C, 32'h00000001, 32'h00000000, 1'b1}};

   adc_conversion_sequencer u_adc_conversion_sequencer (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mod_bit(mod_bit), .cfg(cfg),
      .mod_enable(mod_enable), .offset_pol(offset_pol), .ref_chop(ref_chop),
      .result(result), .conv_done(conv_done));
   // sample enable watched inside the top; rate is set over the bus
   assign fs_tick = u_adc_conversion_sequencer.fs_tick;
   host_model u_host_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // toggling comparator bit, or one that follows the polarity (an input that
   // reverses with the chop, so it survives un-chopping); changes counted while running
   always @(posedge pclk) begin
      mod_bit <= follow_pol ? offset_pol : ~mod_bit;
      if (mod_enable === 1'b1 && offset_pol !== pol_q) tog++;
      if (mod_enable === 1'b1 && ref_chop !== chop_q) ctog++;
      pol_q <= offset_pol;
      chop_q <= ref_chop;
   end

   task automatic conclude();
      if (fails == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // n keeps counting across calls so a restart shows as lateness
   task automatic wait_done();
      do begin @(posedge pclk); n++; end while (conv_done !== 1'b1 && n < 40000);
   endtask

   task automatic wait_tick();
      do begin @(posedge pclk); n++; end while (fs_tick !== 1'b1 && n < 40000);
   endtask

   initial begin
      repeat (95000) @(posedge pclk);
      fails++;
      conclude();
   end

   initial begin
      presetn = 1'b0;
      mod_bit = 1'b0;
      pol_q = 1'b0;
      chop_q = 1'b1;
      follow_pol = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("cfg_rst", conv_cfg_t'{RATE_DEF, OSR_DEF, CNT_DEF, 1'b0, CHOP_DEF, 7'h00, 7'h00}, cfg)
      foreach (rows[i]) begin
         u_host_model.xfer(1'b1, rows[i].a, rows[i].d, q, e);
         u_host_model.xfer(1'b0, rows[i].a, 32'h0, q, e);
         `CHK("reg_rd", rows[i].r, q)
         `CHK("reg_err", rows[i].err, e)
      end
      for (int m = 0; m < 4; m++) begin
         u_host_model.xfer(1'b1, ADDR_CFG_A, 32'(m) << CHOP_LSB, q, e);
         // chop level follows the new mode one edge after the write lands
         @(posedge pclk);
         @(negedge pclk);
         `CHK("chop_mode", 2'(m), cfg.chop)
         `CHK("chop_idle", (m != 1), ref_chop)
      end
      // single run; a second trigger while busy must not restart it
      u_host_model.start(3'h0, 1'b0);
      n = 0;
      tog = 0;
      u_host_model.xfer(1'b0, ADDR_STATUS, 32'h0, q, e);
      `CHK("busy_run", 32'h1, q)
      u_host_model.xfer(1'b0, ADDR_CFG_A, 32'h0, q, e);
      `CHK("start_clr", 32'h20, q)
      repeat (2000) @(posedge pclk);
      u_host_model.start(3'h0, 1'b0);
      n = n + 2009;
      wait_done();
      `CHK("conv_len", 1'b1, (n >= LO1 && n <= HI1))
      `CHK("pol_alt", 1'b1, (tog >= 1 && tog <= 3))
      @(posedge pclk);
      `CHK("done_pulse", 1'b0, conv_done)
      repeat (3) @(posedge pclk);
      u_host_model.xfer(1'b0, ADDR_STATUS, 32'h0, q, e);
      `CHK("busy_end", 32'h0, q)
      // continuous runs back to back
      u_host_model.start(3'h0, 1'b1);
      n = 0;
      wait_done();
      `CHK("cont_len1", 1'b1, (n >= LO1 && n <= HI1))
      n = 0;
      wait_done();
      `CHK("cont_len2", 1'b1, (n >= LO1 - 4 && n <= HI1))
      @(posedge pclk);
      `CHK("cont_run", 1'b1, mod_enable)
      // defaults abandon the running conversion and start a new one
      repeat (1000) @(posedge pclk);
      u_host_model.xfer(1'b1, ADDR_CTRL, 32'h1, q, e);
      @(negedge pclk);
      `CHK("def_cfg", conv_cfg_t'{RATE_DEF, OSR_DEF, CNT_DEF, 1'b0, CHOP_DEF, GAIN_DEF,
         OFFS_DEF}, cfg)
      n = 0;
      wait_done();
      `CHK("def_len", 1'b1, (n >= LO2 && n <= HI2))
      repeat (3) @(posedge pclk);
      `CHK("def_stop", 1'b0, mod_enable)
      // polarity-following input: both halves read full negative scale, mean saturates
      follow_pol <= 1'b1;
      ctog = 0;
      u_host_model.xfer(1'b1, ADDR_CFG_A, 32'h00000321, q, e);
      n = 0;
      wait_done();
      `CHK("result", 16'h8000, result)
      `CHK("chop_half", 1, ctog)
      u_host_model.xfer(1'b0, ADDR_RESULT, 32'h0, q, e);
      `CHK("result_rd", 32'h00008000, q)
      // four sample periods, 8000 pclk in all at rate code 0, divided by two per rate step
      for (int c = 0; c < 4; c++) begin
         u_host_model.xfer(1'b1, ADDR_CFG_B, 32'(c) << RATE_LSB, q, e);
         n = 0;
         repeat (2) wait_tick();
         n = 0;
         repeat (4) wait_tick();
         `CHK("fs_period", 1'b1, (n >= (8000 >> c) - 4 && n <= (8000 >> c) + 4))
      end
      conclude();
   end
endmodule
`default_nettype wire
